/* File: pss_pkg.sv */
`default_nettype none

package pss_pkg;

    // Clock and millisecond time base.
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_PERIOD_NS = TICK_PERIOD_MS * 1000 * 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Fixed acquisition and mode limits, in milliseconds.
    localparam logic [31:0] ACQ_NOSIG_MS = 32'd15000;
    localparam logic [31:0] CYCLIC_MIN_MS = 32'd500;
    localparam logic [31:0] CYCLIC_MAX_MS = 32'd10000;
    localparam logic [31:0] MS_PER_WEEK = 32'd604800000;
    localparam logic [31:0] POT_TRACK_MS = 32'd100;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_UPDATE = 8'h04;
    localparam logic [7:0] ADDR_SEARCH = 8'h08;
    localparam logic [7:0] ADDR_MIN_ACQ = 8'h0c;
    localparam logic [7:0] ADDR_MAX_ACQ = 8'h10;
    localparam logic [7:0] ADDR_HOLD = 8'h14;
    localparam logic [7:0] ADDR_INACT = 8'h18;
    localparam logic [7:0] ADDR_MARGIN = 8'h1c;
    localparam logic [7:0] ADDR_NAV = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_WAKE = 8'h28;

    // Control register field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_NEVER_SLEEP = 2;
    localparam int CTRL_PIN_SEL = 3;
    localparam int CTRL_FORCE_ON = 4;
    localparam int CTRL_FORCE_OFF = 5;
    localparam int CTRL_INACT = 6;
    localparam int CTRL_TP_EN = 7;

    // Reset values, times in milliseconds.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [31:0] RST_UPDATE = 32'd1000;
    localparam logic [31:0] RST_SEARCH = 32'd10000;
    localparam logic [31:0] RST_MIN_ACQ = 32'd0;
    localparam logic [31:0] RST_MAX_ACQ = 32'd300000;
    localparam logic [31:0] RST_HOLD = 32'd0;
    localparam logic [31:0] RST_INACT = 32'd10000;
    localparam logic [31:0] RST_MARGIN = 32'd0;
    localparam logic [31:0] RST_NAV = 32'd1000;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS = 2'h0,
        MODE_ON_OFF = 2'h1,
        MODE_CYCLIC = 2'h2
    } pss_mode_t;

    typedef enum logic [4:0] {
        ST_WAIT_FIX = 5'h01,
        ST_WAIT_SEARCH = 5'h02,
        ST_ACQ = 5'h04,
        ST_TRACK = 5'h08,
        ST_POT = 5'h10
    } pss_state_t;

    typedef enum logic [1:0] {
        PH_NONE = 2'h0,
        PH_TRACK = 2'h1,
        PH_FIX = 2'h2,
        PH_IDLE = 2'h3
    } pss_phase_t;

endpackage

`default_nettype wire

/* File: pss_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } pss_sync_t;

    pss_sync_t r;
    pss_sync_t n;

    always_comb begin
        n = r;
        n.s1 = pin_in;
        n.s2 = r.s1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pin_sync = r.s2;
endmodule

`default_nettype wire

/* File: pss_tick.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_tick #(
    parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } pss_tick_t;

    pss_tick_t r;
    pss_tick_t n;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.cnt >= 16'(TICK_CYCLES - 1)) begin
            n.cnt = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = 16'(r.cnt + 16'h0001);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;
endmodule

`default_nettype wire

/* File: pss_top.sv */
// Overview of operation
// - Cyclic tracking only with fix period from 0.5 s to 10 s.
// - On/off mode only with fix periods above 10 s or a zero fix period.
// - Five states: wait fix, wait search, acquisition, tracking, POWER_OPTIMISED_TRACKING_STATE.
// - Inactive states power down; acquisition full power; tracking downloads.
// - POWER_OPTIMISED_TRACKING_STATE cycles track, fix, idle; no acquisition, no download.
// - Entry to power saving states waits for time pulse readiness.
// - Weak signals leave acquisition at max time, earlier if too few.
// - No signals leave acquisition after 15 s or max time if shorter.
// - Acquisition lasts at least min time before tracking and times out at max.
// - Never-sleep keeps acquisition running instead of timing out.
// - Force-on pin high keeps awake; force-off pin low keeps inactive.
// - Toggling pin keeps awake; quiet beyond period forces inactive.
// - On/off: fail goes wait search, restart at search period less margin.
// - A filtered valid fix enters tracking and starts hold time.
// - On/off: hold expiry enters wait fix, restart on update grid.
// - On/off: lost signal returns to acquisition, then tracking or sleep.
// - Cyclic: fail goes wait search, restart on search grid.
// - Cyclic: hold expiry moves tracking into POWER_OPTIMISED_TRACKING_STATE.
// - POWER_OPTIMISED_TRACKING_STATE fixes at navigation rate; zero hold enters POWER_OPTIMISED_TRACKING_STATE at once.
// - Weak signal in POWER_OPTIMISED_TRACKING_STATE goes tracking; back after good plus hold.
// - Cyclic tracking fix failure goes acquisition; never-sleep stays there.
// - Zero update period waits in wait fix until host wakes it.
// - Zero search period waits in wait search until any wake event.
// - External power control overrides internal state decisions.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pss_top #(
    parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic [1:0] external_wake_pin,
    input wire logic fix_valid,
    input wire logic signal_good,
    input wire logic signal_weak,
    input wire logic signal_lost,
    input wire logic weak_only,
    input wire logic too_few,
    input wire logic no_signals,
    input wire logic time_pulse_ready,
    output logic [2:0] state_code,
    output logic receiver_power_on,
    output logic acq_engine_on,
    output logic track_engine_on,
    output logic data_download_on,
    output logic [1:0] pot_phase
);
    import pss_pkg::*;

    typedef struct packed {
        pss_state_t st;
        logic [1:0] power_mode_select;
        logic never_sleep_option;
        logic pin_sel;
        logic pin_force_on_enable;
        logic pin_force_off_enable;
        logic pin_inactivity_sleep_enable;
        logic time_pulse_enable;
        logic cfg_err;
        logic [31:0] fix_update_period;
        logic [31:0] search_period;
        logic [31:0] min_acquisition_time;
        logic [31:0] max_acquisition_time;
        logic [31:0] tracking_hold_time;
        logic [31:0] pin_inactivity_period;
        logic [31:0] startup_margin;
        logic [31:0] nav_period;
        logic [31:0] acq_ms;
        logic [31:0] hold_ms;
        logic [31:0] upd_grid;
        logic [31:0] srch_grid;
        logic [31:0] inact_ms;
        logic [31:0] pot_ms;
        logic pin_prev;
        logic wake_req;
        logic [31:0] rd_data;
        logic [2:0] code;
        logic pwr_on;
        logic acq_on;
        logic trk_on;
        logic dl_on;
        logic [1:0] phase;
    } pss_regs_t;

    pss_regs_t r;
    pss_regs_t n;
    logic tick;
    logic [1:0] pin_s;

    pss_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in(external_wake_pin),
        .pin_sync(pin_s)
    );

    pss_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick)
    );

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hffffffff) ? v : 32'(v + 32'h00000001);
    endfunction

    // A grid counter runs modulo its period; a zero period clears it and keeps it at zero.
    function automatic logic [31:0] grid_step(input logic [31:0] g,
                                              input logic [31:0] per);
        if (per == 32'h00000000) begin
            grid_step = 32'h00000000;
        end else if (g >= 32'(per - 32'h00000001)) begin
            grid_step = 32'h00000000;
        end else begin
            grid_step = 32'(g + 32'h00000001);
        end
    endfunction

    function automatic logic [31:0] wake_point(input logic [31:0] per,
                                               input logic [31:0] margin);
        // A grid only counts up to per - 1, so a zero margin wakes at 0.
        wake_point = (per > margin && margin != 32'h00000000) ?
                     32'(per - margin) : 32'h00000000;
    endfunction

    function automatic logic [2:0] encode_state(input pss_state_t s);
        case (s)
            ST_WAIT_FIX: encode_state = 3'h0;
            ST_WAIT_SEARCH: encode_state = 3'h1;
            ST_ACQ: encode_state = 3'h2;
            ST_TRACK: encode_state = 3'h3;
            ST_POT: encode_state = 3'h4;
            default: encode_state = 3'h7;
        endcase
    endfunction

    logic pin_level;
    logic pin_toggled;
    logic force_awake;
    logic force_asleep;
    logic sleep_ok;
    logic psm_on;
    logic on_off;
    logic cyclic;
    logic min_done;
    logic acq_timeout;
    logic upd_hit;
    logic srch_hit;
    logic [31:0] nosig_limit;
    logic [31:0] srch_point;

    always_comb begin
        n = r;

        // Mode checks against the fix period; a bad pairing falls back
        // to continuous operation rather than running out of range.
        n.cfg_err = 1'b0;
        if (r.power_mode_select == MODE_CYCLIC) begin
            n.cfg_err = (r.fix_update_period < CYCLIC_MIN_MS) ||
                        (r.fix_update_period > CYCLIC_MAX_MS);
        end else if (r.power_mode_select == MODE_ON_OFF) begin
            n.cfg_err = (r.fix_update_period != 32'h00000000) &&
                        (r.fix_update_period <= CYCLIC_MAX_MS);
        end
        psm_on = !r.cfg_err && (r.power_mode_select != MODE_CONTINUOUS);
        on_off = psm_on && (r.power_mode_select == MODE_ON_OFF);
        cyclic = psm_on && (r.power_mode_select == MODE_CYCLIC);

        // Pin control from the selected synchronised wake pin.
        pin_level = r.pin_sel ? pin_s[1] : pin_s[0];
        pin_toggled = pin_level != r.pin_prev;
        n.pin_prev = pin_level;
        if (pin_toggled) begin
            n.inact_ms = 32'h00000000;
        end else if (tick) begin
            n.inact_ms = sat_inc(r.inact_ms);
        end
        force_awake = (r.pin_force_on_enable && pin_level) ||
                      (r.pin_inactivity_sleep_enable &&
                       r.inact_ms <= r.pin_inactivity_period);
        force_asleep = !force_awake &&
                       ((r.pin_force_off_enable && !pin_level) ||
                        (r.pin_inactivity_sleep_enable &&
                         r.inact_ms > r.pin_inactivity_period));

        sleep_ok = !r.time_pulse_enable || time_pulse_ready;

        // Millisecond counters.
        if (tick) begin
            n.acq_ms = sat_inc(r.acq_ms);
            n.hold_ms = sat_inc(r.hold_ms);
            n.upd_grid = grid_step(r.upd_grid, r.fix_update_period);
            n.srch_grid = grid_step(r.srch_grid, r.search_period);
            n.pot_ms = grid_step(r.pot_ms, r.nav_period);
        end

        // Zero periods never produce a grid wake.
        upd_hit = (r.fix_update_period != 32'h00000000) &&
                  (r.upd_grid == wake_point(r.fix_update_period,
                                            r.startup_margin));
        srch_point = on_off ? wake_point(r.search_period, r.startup_margin)
                            : 32'h00000000;
        srch_hit = (r.search_period != 32'h00000000) &&
                   (r.srch_grid == srch_point);

        nosig_limit = (r.max_acquisition_time < ACQ_NOSIG_MS) ?
                      r.max_acquisition_time : ACQ_NOSIG_MS;
        min_done = r.acq_ms >= r.min_acquisition_time;
        acq_timeout = (r.acq_ms >= r.max_acquisition_time) ||
                      (min_done && weak_only && too_few) ||
                      (min_done && no_signals &&
                       r.acq_ms >= nosig_limit);

        case (r.st)
            ST_WAIT_FIX: begin
                if (!force_asleep && (!psm_on || force_awake ||
                                      r.wake_req || upd_hit)) begin
                    n.st = ST_ACQ;
                end
            end
            ST_WAIT_SEARCH: begin
                if (!force_asleep && (!psm_on || force_awake ||
                                      r.wake_req || srch_hit)) begin
                    n.st = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (fix_valid && min_done) begin
                    n.st = ST_TRACK;
                end else if (psm_on && !r.never_sleep_option &&
                             !force_awake && sleep_ok && acq_timeout) begin
                    n.st = ST_WAIT_SEARCH;
                end
            end
            ST_TRACK: begin
                if (signal_lost) begin
                    n.st = ST_ACQ;
                end else if (r.hold_ms >= r.tracking_hold_time) begin
                    if (on_off && sleep_ok && !force_awake) begin
                        n.st = ST_WAIT_FIX;
                    end else if (cyclic && signal_good && sleep_ok) begin
                        n.st = ST_POT;
                    end
                end
            end
            ST_POT: begin
                if (signal_weak || signal_lost || !cyclic) begin
                    n.st = ST_TRACK;
                end
            end
            default: begin
                n.st = ST_ACQ;
            end
        endcase

        // Pin control overrides whatever the internal logic decided.
        if (force_asleep && (r.st == ST_ACQ || r.st == ST_TRACK ||
                             r.st == ST_POT)) begin
            n.st = ST_WAIT_FIX;
        end

        if (n.st == ST_ACQ && r.st != ST_ACQ) begin
            n.acq_ms = 32'h00000000;
        end
        if (n.st == ST_TRACK && r.st != ST_TRACK) begin
            n.hold_ms = 32'h00000000;
        end
        if (n.st == ST_POT && r.st != ST_POT) begin
            n.pot_ms = 32'h00000000;
        end

        // A pending host wake is used up on leaving an inactive state.
        if ((r.st == ST_WAIT_FIX || r.st == ST_WAIT_SEARCH) &&
            n.st == ST_ACQ) begin
            n.wake_req = 1'b0;
        end

        // Register writes; a new wake request beats the clear above.
        if (wr_en) begin
            if (addr == ADDR_CTRL) begin
                n.power_mode_select = wr_data[CTRL_MODE_LSB +: 2];
                n.never_sleep_option = wr_data[CTRL_NEVER_SLEEP];
                n.pin_sel = wr_data[CTRL_PIN_SEL];
                n.pin_force_on_enable = wr_data[CTRL_FORCE_ON];
                n.pin_force_off_enable = wr_data[CTRL_FORCE_OFF];
                n.pin_inactivity_sleep_enable = wr_data[CTRL_INACT];
                n.time_pulse_enable = wr_data[CTRL_TP_EN];
            end else if (addr == ADDR_UPDATE) begin
                // Periods longer than a week are refused and the old
                // value stays in force.
                if (wr_data <= MS_PER_WEEK) begin
                    n.fix_update_period = wr_data;
                end
            end else if (addr == ADDR_SEARCH) begin
                if (wr_data <= MS_PER_WEEK) begin
                    n.search_period = wr_data;
                end
            end else if (addr == ADDR_MIN_ACQ) begin
                n.min_acquisition_time = wr_data;
            end else if (addr == ADDR_MAX_ACQ) begin
                n.max_acquisition_time = wr_data;
            end else if (addr == ADDR_HOLD) begin
                n.tracking_hold_time = wr_data;
            end else if (addr == ADDR_INACT) begin
                n.pin_inactivity_period = wr_data;
            end else if (addr == ADDR_MARGIN) begin
                n.startup_margin = wr_data;
            end else if (addr == ADDR_NAV) begin
                n.nav_period = wr_data;
            end else if (addr == ADDR_WAKE) begin
                if (wr_data[0]) begin
                    n.wake_req = 1'b1;
                end
            end
        end

        // Read data stands for one cycle only, zero otherwise.
        n.rd_data = 32'h00000000;
        if (rd_en) begin
            if (addr == ADDR_CTRL) begin
                n.rd_data = {24'h000000, r.time_pulse_enable,
                             r.pin_inactivity_sleep_enable,
                             r.pin_force_off_enable, r.pin_force_on_enable,
                             r.pin_sel, r.never_sleep_option,
                             r.power_mode_select};
            end else if (addr == ADDR_UPDATE) begin
                n.rd_data = r.fix_update_period;
            end else if (addr == ADDR_SEARCH) begin
                n.rd_data = r.search_period;
            end else if (addr == ADDR_MIN_ACQ) begin
                n.rd_data = r.min_acquisition_time;
            end else if (addr == ADDR_MAX_ACQ) begin
                n.rd_data = r.max_acquisition_time;
            end else if (addr == ADDR_HOLD) begin
                n.rd_data = r.tracking_hold_time;
            end else if (addr == ADDR_INACT) begin
                n.rd_data = r.pin_inactivity_period;
            end else if (addr == ADDR_MARGIN) begin
                n.rd_data = r.startup_margin;
            end else if (addr == ADDR_NAV) begin
                n.rd_data = r.nav_period;
            end else if (addr == ADDR_STATUS) begin
                n.rd_data = {23'h000000, r.wake_req, force_asleep,
                             force_awake, r.phase, r.cfg_err,
                             r.code};
            end
        end

        // Outputs follow the next state so they change with it.
        n.code = encode_state(n.st);
        n.pwr_on = (n.st != ST_WAIT_FIX) && (n.st != ST_WAIT_SEARCH);
        n.acq_on = n.st == ST_ACQ;
        n.trk_on = (n.st == ST_TRACK) || (n.st == ST_POT) ||
                   (n.st == ST_ACQ);
        n.dl_on = n.st == ST_TRACK;
        if (n.st != ST_POT) begin
            n.phase = PH_NONE;
        end else if (n.pot_ms < POT_TRACK_MS) begin
            n.phase = PH_TRACK;
        end else if (n.pot_ms == POT_TRACK_MS) begin
            n.phase = PH_FIX;
        end else begin
            n.phase = PH_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= ST_ACQ;
            r.power_mode_select <= RST_CTRL[CTRL_MODE_LSB +: 2];
            r.fix_update_period <= RST_UPDATE;
            r.search_period <= RST_SEARCH;
            r.min_acquisition_time <= RST_MIN_ACQ;
            r.max_acquisition_time <= RST_MAX_ACQ;
            r.tracking_hold_time <= RST_HOLD;
            r.pin_inactivity_period <= RST_INACT;
            r.startup_margin <= RST_MARGIN;
            r.nav_period <= RST_NAV;
            r.code <= 3'h2;
            r.pwr_on <= 1'b1;
            r.acq_on <= 1'b1;
            r.trk_on <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign rd_data = r.rd_data;
    assign state_code = r.code;
    assign receiver_power_on = r.pwr_on;
    assign acq_engine_on = r.acq_on;
    assign track_engine_on = r.trk_on;
    assign data_download_on = r.dl_on;
    assign pot_phase = r.phase;
endmodule

`default_nettype wire

/* File: pss_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pss_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic fix_valid,
    input wire logic signal_lost,
    input wire logic [2:0] state_code,
    input wire logic receiver_power_on,
    input wire logic acq_engine_on,
    input wire logic track_engine_on,
    input wire logic data_download_on,
    input wire logic [1:0] pot_phase
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence acq_then_trk;
        state_code == 3'h2 ##1 state_code == 3'h3;
    endsequence
    sequence trk_then_acq;
        state_code == 3'h3 ##1 state_code == 3'h2;
    endsequence
    state_range_a: assert property (state_code <= 3'h4)
        else $error("state code out of range");
    power_map_a: assert property (receiver_power_on == (state_code >= 3'h2))
        else $error("power enable wrong");
    acq_engine_a: assert property (acq_engine_on == (state_code == 3'h2))
        else $error("acq engine wrong");
    track_engine_a: assert property (track_engine_on == (state_code >= 3'h2))
        else $error("track engine wrong");
    download_only_a: assert property (data_download_on == (state_code == 3'h3))
        else $error("download wrong");
    pot_phase_a: assert property (state_code != 3'h4 |-> pot_phase == 2'h0)
        else $error("phase outside pot");
    pot_busy_a: assert property (state_code == 3'h4 |-> pot_phase != 2'h0)
        else $error("no phase inside pot");
    fix_entry_a: assert property (acq_then_trk |-> $past(fix_valid))
        else $error("tracking without fix");
    lost_exit_a: assert property (trk_then_acq |-> $past(signal_lost))
        else $error("acq without loss");
    pot_entry_a: assert property ($changed(state_code) && state_code == 3'h4 |-> $past(state_code) == 3'h3)
        else $error("pot not from tracking");
    read_idle_a: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data not idle");
endmodule
bind pss_top pss_properties chk_u (.clock(clock), .rst_n(rst_n),
    .rd_en(rd_en), .rd_data(rd_data), .fix_valid(fix_valid),
    .signal_lost(signal_lost), .state_code(state_code),
    .receiver_power_on(receiver_power_on), .acq_engine_on(acq_engine_on),
    .track_engine_on(track_engine_on), .data_download_on(data_download_on),
    .pot_phase(pot_phase));
`default_nettype wire

/* File: pss_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pss_host_model (
    input wire logic clock,
    input wire logic [1:0] level,
    input wire logic toggle,
    output var logic [1:0] pin
);
    logic [2:0] cnt_r = 3'h0;
    initial pin = 2'h3;
    // Pins move a few ns after the edge, as an unrelated host would.
    always @(posedge clock) begin
        cnt_r <= cnt_r + 3'h1;
        if (toggle && cnt_r == 3'h0) begin
            pin[0] <= #3 ~pin[0];
        end else if (!toggle) begin
            pin <= #3 level;
        end
    end
endmodule
`default_nettype wire

/* File: power_save_state_machine_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module power_save_state_machine_tb;
    import pss_pkg::*;
    localparam int TC = 10;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [6:0] sig = 7'h0;
    logic tp_ready = 1'b1;
    logic [1:0] pin_lvl = 2'h3;
    logic pin_tgl = 1'b0;
    logic [1:0] pins, pot_phase;
    logic [2:0] state_code;
    logic [31:0] rd_data, got, ev;
    logic pwr, acq_on, trk_on, dl_on;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] rst_tbl [8] = '{RST_UPDATE, RST_SEARCH, RST_MIN_ACQ,
        RST_MAX_ACQ, RST_HOLD, RST_INACT, RST_MARGIN, RST_NAV};
    always #10 clock = ~clock;
    pss_top #(.TICK_CYCLES(TC)) dut_u (.clock(clock), .rst_n(rst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .external_wake_pin(pins), .fix_valid(sig[6]),
        .signal_good(sig[5]), .signal_weak(sig[4]), .signal_lost(sig[3]),
        .weak_only(sig[2]), .too_few(sig[1]), .no_signals(sig[0]),
        .time_pulse_ready(tp_ready), .state_code(state_code),
        .receiver_power_on(pwr), .acq_engine_on(acq_on),
        .track_engine_on(trk_on), .data_download_on(dl_on),
        .pot_phase(pot_phase));
    pss_host_model host_u (.clock(clock), .level(pin_lvl),
        .toggle(pin_tgl), .pin(pins));
    function automatic int cyc(input int ms_v);
        return ms_v * TC + 8;
    endfunction
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic wait_st(input logic [2:0] e, input int n);
        for (int i = 0; i < n && state_code !== e; i++) begin
            @(posedge clock);
            #1;
        end
        chk(32'(state_code), 32'(e));
    endtask
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(58));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        wait_st(3'h2, 1);
        rd(ADDR_CTRL, got);
        chk(got, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rd(8'h04 + 8'(i * 4), got);
            chk(got, rst_tbl[i]);
        end
        rd(8'h3c, got);
        chk(got, 32'h0);
        wr(ADDR_UPDATE, MS_PER_WEEK + 32'h1);
        rd(ADDR_UPDATE, got);
        chk(got, RST_UPDATE);
        repeat (3) begin
            ev = $urandom % 32'd9000;
            wr(ADDR_INACT, ev);
            rd(ADDR_INACT, got);
            chk(got, ev);
        end
        wr(ADDR_UPDATE, 32'h0);
        wr(ADDR_SEARCH, 32'h0);
        wr(ADDR_HOLD, 32'h3);
        wr(ADDR_CTRL, 32'h1);
        sig <= 7'h40;
        wait_st(3'h3, 4);
        sig <= 7'h20;
        repeat (2 * TC) @(posedge clock);
        wait_st(3'h3, 0);
        wait_st(3'h0, cyc(1));
        wr(ADDR_MAX_ACQ, 32'h5);
        repeat (cyc(20)) @(posedge clock);
        wait_st(3'h0, 0);
        wr(ADDR_WAKE, 32'h1);
        wait_st(3'h2, 4);
        sig <= 7'h01;
        wait_st(3'h1, cyc(5));
        sig <= 7'h00;
        repeat (cyc(20)) @(posedge clock);
        wait_st(3'h1, 0);
        wr(ADDR_WAKE, 32'h1);
        wait_st(3'h2, 4);
        wr(ADDR_CTRL, 32'h6);
        rd(ADDR_STATUS, got);
        chk(got, 32'ha);
        wr(ADDR_UPDATE, 32'd1000);
        wr(ADDR_HOLD, 32'h0);
        sig <= 7'h01;
        repeat (cyc(10)) @(posedge clock);
        wait_st(3'h2, 0);
        sig <= 7'h60;
        wait_st(3'h4, cyc(2));
        chk(32'(pot_phase), 32'h1);
        sig <= 7'h10;
        wait_st(3'h3, 4);
        sig <= 7'h08;
        wait_st(3'h2, 4);
        wr(ADDR_CTRL, 32'h22);
        pin_lvl <= 2'h2;
        wait_st(3'h0, 8);
        pin_lvl <= 2'h3;
        wr(ADDR_INACT, 32'h2);
        wr(ADDR_CTRL, 32'h42);
        pin_tgl <= 1'b1;
        sig <= 7'h40;
        repeat (cyc(5)) @(posedge clock);
        chk(32'(pwr), 32'h1);
        pin_tgl <= 1'b0;
        wait_st(3'h0, cyc(4));
        rd(ADDR_STATUS, got);
        chk(got, 32'h80);
        wrap_up();
    end
endmodule
`default_nettype wire
